/* File: shared/oxd_pkg.sv */
// Purpose: constants and types for the oximeter display and status controller
// Assumes: 50 MHz aclk, millisecond tick derived by a divider
// Notes: every time below counts ticks of the millisecond enable
`default_nettype none
package oxd_pkg;
  localparam int CLK_HZ = 50000000;
  localparam int CYC_PER_MS_DEF = CLK_HZ / 1000;
  localparam int TMR_W = 20;
  // times in milliseconds
  localparam logic [19:0] FREEZE_MS = 20'd10000;
  localparam logic [19:0] CRIT_OFF_MS = 20'd600000;
  localparam logic [19:0] IDLE_OFF_MS = 20'd600000;
  localparam logic [19:0] HOLD_OFF_MS = 20'd2000;
  localparam logic [19:0] UPD_MS = 20'd1500;
  localparam logic [19:0] STALE_MS = 20'd30000;
  localparam logic [19:0] LAMP_MS = 20'd1000;
  localparam logic [19:0] BATT_MS = 20'd3000;
  localparam logic [19:0] COLOR_MS = 20'd1000;
  localparam logic [19:0] CLOCK_MS = 20'd1000;
  localparam logic [19:0] REV_MS = 20'd1000;
  localparam logic [19:0] FLASH_MS = 20'd100;
  localparam logic [19:0] BLINK_MS = 20'd500;
  // digit codes: 0..9 are decimal digits
  localparam logic [3:0] DIG_DASH = 4'hA;
  localparam logic [3:0] DIG_BLANK = 4'hB;
  localparam logic [3:0] DIG_R = 4'hC;
  localparam logic [3:0] DIG_N = 4'hD;
  localparam logic [3:0] DIG_ALL = 4'hE;
  // signal grades
  localparam logic [1:0] GRADE_GOOD = 2'h0;
  localparam logic [1:0] GRADE_MARG = 2'h1;
  localparam logic [1:0] GRADE_BAD = 2'h2;
  // register byte offsets
  localparam logic [3:0] REG_CLOCK = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_REV = 4'h8;
  localparam logic [31:0] CLOCK_RST = 32'h0000_0000;
  // revision codes, values arbitrary
  localparam logic [11:0] MAIN_REV_DEF = 12'h123;
  localparam logic [11:0] MEM_REV_DEF = 12'h456;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0] d2;
    logic [3:0] d1;
    logic [3:0] d0;
  } oxd_disp_type;

  typedef struct packed {
    logic red;
    logic green;
  } oxd_led_type;

  typedef enum logic [8:0] {
    ST_OFF = 9'h001,
    ST_LAMP = 9'h002,
    ST_BATT = 9'h004,
    ST_RED = 9'h008,
    ST_GREEN = 9'h010,
    ST_CLOCK = 9'h020,
    ST_REVM = 9'h040,
    ST_REVN = 9'h080,
    ST_RUN = 9'h100
  } oxd_state_type;
endpackage : oxd_pkg
`default_nettype wire

/* File: hdl/oxd_display_ctrl.sv */
// Purpose: display, indicator and power sequencing of a handheld oximeter
// Assumes: measurement engine and battery monitor on aclk; button is a raw pin
// Notes: registers reached over AXI4-Lite; leading zeros of readings are blanked
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`default_nettype none
module oxd_display_ctrl
  import oxd_pkg::*;
#(
  parameter int CYC_PER_MS = CYC_PER_MS_DEF
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // measurement engine
  input wire logic pulse_evt,
  input wire logic [1:0] grade,
  input wire logic sensor_fault,
  input wire logic signal_lost,
  input wire logic meas_upd,
  input wire logic [6:0] spo2_in,
  input wire logic [8:0] rate_in,
  // battery monitor and button
  input wire logic batt_low,
  input wire logic batt_crit,
  input wire logic onoff_btn,
  // displays and indicators
  output oxd_disp_type spo2_disp,
  output oxd_disp_type rate_disp,
  output oxd_led_type pq_led,
  output logic batt_led,
  output logic power_en,
  // axi4-lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  oxd_state_type state;
  oxd_state_type next_state;
  logic [31:0] ms_div;
  logic ms_tick;
  logic btn_m, btn_s, btn_q, armed;
  logic [19:0] st_ms, hold_ms, crit_ms, idle_ms, frz_ms, upd_ms, stale_ms, flash_ms, blink_ms;
  logic blink;
  logic valid_seen, fault_q;
  logic [6:0] live_spo2, shown_spo2;
  logic [8:0] live_rate, shown_rate;
  oxd_led_type flash_col;
  logic [31:0] clock_reg;
  oxd_disp_type next_spo2, next_rate;
  oxd_led_type next_pq;
  logic next_batt;
  logic fault, sens_fault, dashed, stale, run, shutdown, upd_hit;
  // binary value to three digits with leading zeros blanked
  function automatic oxd_disp_type to_disp(input logic [9:0] v);
    oxd_disp_type d;
    d.d2 = 4'(v / 10'd100);
    d.d1 = 4'((v / 10'd10) % 10'd10);
    d.d0 = 4'(v % 10'd10);
    if (d.d2 == 4'h0) begin
      d.d2 = DIG_BLANK;
      if (d.d1 == 4'h0) begin
        d.d1 = DIG_BLANK;
      end
    end
    return d;
  endfunction : to_disp
  // millisecond enable; all timers count these
  always_ff @(posedge aclk) begin
    if (!aresetn || ms_div == 32'(CYC_PER_MS - 1)) begin
      ms_div <= 32'h0000_0000;
    end else begin
      ms_div <= ms_div + 32'h0000_0001;
    end
  end
  assign ms_tick = (ms_div == 32'(CYC_PER_MS - 1));
  // button pin synchroniser and previous sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      btn_m <= 1'b0;
      btn_s <= 1'b0;
      btn_q <= 1'b0;
    end else begin
      btn_m <= onoff_btn;
      btn_s <= btn_m;
      btn_q <= btn_s;
    end
  end
  assign run = (state == ST_RUN);
  assign sens_fault = sensor_fault | signal_lost;
  assign fault = sens_fault | (grade == GRADE_BAD);
  assign dashed = fault && (frz_ms >= FREEZE_MS);
  assign stale = (stale_ms > STALE_MS);
  assign upd_hit = ms_tick && (upd_ms == UPD_MS - 20'd1);
  assign shutdown = (hold_ms >= HOLD_OFF_MS)
    || (crit_ms >= CRIT_OFF_MS)
    || (run && idle_ms >= IDLE_OFF_MS);
  // power-on arming: only a press that starts while off counts
  always_ff @(posedge aclk) begin
    if (!aresetn || state != ST_OFF) begin
      armed <= 1'b0;
    end else if (btn_s && !btn_q) begin
      armed <= 1'b1;
    end
  end
  // power and startup sequence
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: if (armed && !btn_s) next_state = ST_LAMP;
      ST_LAMP: if (st_ms >= LAMP_MS) next_state = ST_BATT;
      ST_BATT: if (st_ms >= BATT_MS) next_state = ST_RED;
      ST_RED: if (st_ms >= COLOR_MS) next_state = ST_GREEN;
      ST_GREEN: if (st_ms >= COLOR_MS) next_state = ST_CLOCK;
      ST_CLOCK: if (st_ms >= CLOCK_MS) next_state = ST_REVM;
      ST_REVM: if (st_ms >= REV_MS) next_state = ST_REVN;
      ST_REVN: if (st_ms >= REV_MS) next_state = ST_RUN;
      ST_RUN: next_state = ST_RUN;
      default: next_state = ST_OFF;
    endcase
    if (state != ST_OFF && shutdown) begin
      next_state = ST_OFF;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end
  // time spent in the current state
  always_ff @(posedge aclk) begin
    if (!aresetn || next_state != state) begin
      st_ms <= 20'h00000;
    end else if (ms_tick) begin
      st_ms <= st_ms + 20'h00001;
    end
  end
  // button hold time while powered
  always_ff @(posedge aclk) begin
    if (!aresetn || state == ST_OFF || !btn_s) begin
      hold_ms <= 20'h00000;
    end else if (ms_tick) begin
      hold_ms <= hold_ms + 20'h00001;
    end
  end
  // critical battery duration, restarts when the flag drops
  always_ff @(posedge aclk) begin
    if (!aresetn || state == ST_OFF || !batt_crit) begin
      crit_ms <= 20'h00000;
    end else if (ms_tick) begin
      crit_ms <= crit_ms + 20'h00001;
    end
  end
  // inactivity: time spent showing dashes
  always_ff @(posedge aclk) begin
    if (!aresetn || !run || (valid_seen && !dashed)) begin
      idle_ms <= 20'h00000;
    end else if (ms_tick) begin
      idle_ms <= idle_ms + 20'h00001;
    end
  end
  // freeze timer; saturates so dashes persist while the fault stays
  always_ff @(posedge aclk) begin
    if (!aresetn || !run || !fault) begin
      frz_ms <= 20'h00000;
    end else if (ms_tick && frz_ms < FREEZE_MS) begin
      frz_ms <= frz_ms + 20'h00001;
    end
  end
  // display refresh period
  always_ff @(posedge aclk) begin
    if (!aresetn || !run || upd_hit) begin
      upd_ms <= 20'h00000;
    end else if (ms_tick) begin
      upd_ms <= upd_ms + 20'h00001;
    end
  end
  // age of pulse-rate data; saturates just past the limit
  always_ff @(posedge aclk) begin
    if (!aresetn || !run || meas_upd) begin
      stale_ms <= 20'h00000;
    end else if (ms_tick && !stale) begin
      stale_ms <= stale_ms + 20'h00001;
    end
  end
  // first valid pulse after startup
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      valid_seen <= 1'b0;
    end else if (pulse_evt && !fault) begin
      valid_seen <= 1'b1;
    end
  end
  // live values from the engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      live_spo2 <= 7'h00;
      live_rate <= 9'h000;
    end else if (meas_upd) begin
      live_spo2 <= spo2_in;
      live_rate <= rate_in;
    end
  end
  // shown values: periodic refresh, held during faults, immediate on recovery
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shown_spo2 <= 7'h00;
      shown_rate <= 9'h000;
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault;
      if (!fault && (upd_hit || fault_q)) begin
        shown_spo2 <= live_spo2;
        shown_rate <= live_rate;
      end
    end
  end
  // pulse flash: one flash per event, color latched at the event
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      flash_ms <= 20'h00000;
      flash_col <= '0;
    end else if (pulse_evt) begin
      flash_ms <= FLASH_MS;
      case (grade)
        GRADE_GOOD: flash_col <= batt_crit ? 2'b11 : 2'b01;
        GRADE_MARG: flash_col <= 2'b11;
        default: flash_col <= 2'b10;
      endcase
    end else if (ms_tick && flash_ms != 20'h00000) begin
      flash_ms <= flash_ms - 20'h00001;
    end
  end
  // slow blink for the critical battery indication
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blink_ms <= 20'h00000;
      blink <= 1'b0;
    end else if (ms_tick) begin
      if (blink_ms >= BLINK_MS - 20'd1) begin
        blink_ms <= 20'h00000;
        blink <= ~blink;
      end else begin
        blink_ms <= blink_ms + 20'h00001;
      end
    end
  end
  // display and indicator content
  always_comb begin
    next_spo2 = '{DIG_BLANK, DIG_BLANK, DIG_BLANK};
    next_rate = '{DIG_BLANK, DIG_BLANK, DIG_BLANK};
    next_pq = '0;
    next_batt = 1'b0;
    case (state)
      ST_LAMP: begin
        next_spo2 = '{DIG_ALL, DIG_ALL, DIG_ALL};
        next_rate = '{DIG_ALL, DIG_ALL, DIG_ALL};
      end
      ST_BATT: next_batt = 1'b1;
      ST_RED: next_pq = 2'b10;
      ST_GREEN: next_pq = 2'b01;
      ST_CLOCK: begin
        next_spo2 = '{DIG_BLANK, clock_reg[15:12], clock_reg[11:8]};
        next_rate = '{DIG_BLANK, clock_reg[7:4], clock_reg[3:0]};
      end
      ST_REVM: begin
        next_spo2 = '{DIG_R, DIG_BLANK, DIG_BLANK};
        next_rate = MAIN_REV_DEF;
      end
      ST_REVN: begin
        next_spo2 = '{DIG_N, DIG_N, DIG_BLANK};
        next_rate = MEM_REV_DEF;
      end
      ST_RUN: begin
        if (batt_crit) begin
          next_batt = blink;
        end else begin
          next_batt = batt_low;
        end
        if (flash_ms != 20'h00000) begin
          next_pq = (batt_crit && flash_col == 2'b01) ? 2'b11 : flash_col;
        end
        if (batt_crit) begin
          next_spo2 = '{DIG_BLANK, DIG_BLANK, DIG_BLANK};
        end else if (!valid_seen || dashed) begin
          next_spo2 = '{DIG_BLANK, DIG_DASH, DIG_BLANK};
          next_rate = '{DIG_BLANK, DIG_DASH, DIG_BLANK};
        end else begin
          next_spo2 = to_disp({3'b000, shown_spo2});
          next_rate = to_disp({1'b0, shown_rate});
          if (stale) begin
            next_rate = '{DIG_BLANK, DIG_DASH, DIG_BLANK};
          end
          if (sens_fault) begin
            next_spo2.d2 = DIG_DASH;
          end
        end
      end
      default: next_batt = 1'b0;
    endcase
  end
  // registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spo2_disp <= '{DIG_BLANK, DIG_BLANK, DIG_BLANK};
      rate_disp <= '{DIG_BLANK, DIG_BLANK, DIG_BLANK};
      pq_led <= '0;
      batt_led <= 1'b0;
      power_en <= 1'b0;
    end else begin
      spo2_disp <= next_spo2;
      rate_disp <= next_rate;
      pq_led <= next_pq;
      batt_led <= next_batt;
      power_en <= (next_state != ST_OFF);
    end
  end
  // write channel: address and data taken together, one write in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      clock_reg <= CLOCK_RST;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        if (s_axi_awaddr[3:2] == REG_CLOCK[3:2]) begin
          s_axi_bresp <= RESP_OKAY;
          for (int i = 0; i < 4; i++) begin
            if (s_axi_wstrb[i]) begin
              clock_reg[i*8 +: 8] <= s_axi_wdata[i*8 +: 8];
            end
          end
        end else begin
          s_axi_bresp <= RESP_SLVERR; // read-only or unmapped
        end
      end
    end
  end
  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (s_axi_araddr[3:2])
          REG_CLOCK[3:2]: s_axi_rdata <= clock_reg;
          REG_STATUS[3:2]: s_axi_rdata <= {18'h00000, batt_crit, stale, dashed,
                                           fault && !dashed, valid_seen, state};
          REG_REV[3:2]: s_axi_rdata <= {8'h00, MAIN_REV_DEF, MEM_REV_DEF};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
    end
  end

endmodule : oxd_display_ctrl
`default_nettype wire

/* File: dv/oxd_display_ctrl_props.sv */
// Purpose: port assertions for the oximeter display controller
// Assumes: one aclk domain, synchronous active-low reset
// Notes: latencies allow for input and output register stages
`default_nettype none
module oxd_props
  import oxd_pkg::*;
#(
  parameter int CYC_PER_MS = CYC_PER_MS_DEF
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // panel side
  input wire logic batt_crit,
  input wire logic onoff_btn,
  input wire oxd_disp_type spo2_disp,
  input wire oxd_disp_type rate_disp,
  input wire oxd_led_type pq_led,
  input wire logic batt_led,
  input wire logic power_en,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dcb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [31:0] held;
  logic [31:0] still;
  // press length; an early off would show as a short count
  always_ff @(posedge aclk) begin
    held <= onoff_btn ? held + 32'h1 : 32'h0;
  end
  // time the battery lamp stands still while critical
  always_ff @(posedge aclk) begin
    still <= (batt_crit && power_en && batt_led == $past(batt_led)) ? still + 32'h1 : 32'h0;
  end
  property p_rst;
    $rose(aresetn) |-> !power_en && !batt_led && pq_led == 2'h0 && spo2_disp == {3{DIG_BLANK}};
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not dark after reset");
  property p_crit_blank;
    batt_crit [*4] |-> spo2_disp == {3{DIG_BLANK}} && rate_disp == {3{DIG_BLANK}};
  endproperty
  a_crit_blank: assert property (p_crit_blank) else $error("numerics shown on low battery");
  property p_crit_col;
    batt_crit [*4] |-> pq_led != 2'h1;
  endproperty
  a_crit_col: assert property (p_crit_col) else $error("green flash on low battery");
  property p_off_dark;
    !power_en [*3] |-> pq_led == 2'h0 && !batt_led;
  endproperty
  a_off_dark: assert property (p_off_dark) else $error("lamp lit while off");
  property p_on;
    $rose(power_en) |-> !$past(onoff_btn) && !$past(onoff_btn, 2);
  endproperty
  a_on: assert property (p_on) else $error("power before button release");
  property p_hold;
    $fell(power_en) && onoff_btn && !batt_crit |-> held >= (HOLD_OFF_MS - 1) * CYC_PER_MS;
  endproperty
  a_hold: assert property (p_hold) else $error("off on a short hold");
  property p_blink;
    power_en && batt_crit |-> still <= (BLINK_MS + 2) * CYC_PER_MS;
  endproperty
  a_blink: assert property (p_blink) else $error("battery lamp not flashing");
  property p_aw;
    s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
      |=> s_axi_awready && s_axi_wready && s_axi_bvalid;
  endproperty
  a_aw: assert property (p_aw) else $error("write not answered");
  property p_ar;
    s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid;
  endproperty
  a_ar: assert property (p_ar) else $error("read not answered");
endmodule : oxd_props
bind oxd_display_ctrl oxd_props #(.CYC_PER_MS(CYC_PER_MS)) u_props (
  .aclk(aclk), .aresetn(aresetn), .batt_crit(batt_crit), .onoff_btn(onoff_btn),
  .spo2_disp(spo2_disp), .rate_disp(rate_disp), .pq_led(pq_led), .batt_led(batt_led),
  .power_en(power_en), .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid)
);
`default_nettype wire

/* File: dv/oxd_engine_model.sv */
// Purpose: behavioural measurement engine giving beats and readings
// Assumes: same aclk as the controller
// Notes: data lines scramble between strobes so stale values never pass
`default_nettype none
module oxd_engine_model
  import oxd_pkg::*;
(
  // clock, reset and control
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [6:0] spo2_val,
  input wire logic [8:0] rate_val,
  // engine outputs
  output logic pulse_evt,
  output logic meas_upd,
  output logic [6:0] spo2_in,
  output logic [8:0] rate_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] phase;
  // one beat and one reading every 1024 cycles
  always_ff @(posedge aclk) begin
    phase <= (!aresetn || !run) ? 10'h000 : phase + 10'h001;
  end
  // one-cycle strobes, as the controller expects
  always_ff @(posedge aclk) begin
    pulse_evt <= aresetn && run && phase == 10'h3FF;
    meas_upd <= aresetn && run && phase == 10'h3FF;
  end
  // readings valid only with the strobe, inverted otherwise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spo2_in <= 7'h00;
      rate_in <= 9'h000;
    end else if (run && phase == 10'h3FF) begin
      spo2_in <= spo2_val;
      rate_in <= rate_val;
    end else begin
      spo2_in <= ~spo2_in;
      rate_in <= ~rate_in;
    end
  end
endmodule : oxd_engine_model
`default_nettype wire

/* File: dv/oxd_display_ctrl_tb_top.sv */
// Purpose: self-checking bench for the oximeter display controller
// Assumes: millisecond tick shortened to two clock cycles
// Notes: drivers queue expectations, one monitor compares them
`default_nettype none
`define CHK(a, e) samples_checked++; \
  if ((a) !== (e)) begin \
    fail_count++; \
    $display("[ERR] %0t got %h want %h", $time, a, e); \
  end
module oxd_display_ctrl_tb_top import oxd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 2;
  typedef struct packed {
    logic [1:0] kind;
    logic [47:0] val;
    logic [47:0] msk;
  } oxd_note_type;
  oxd_note_type notes[$];
  int fail_count = 0;
  int samples_checked = 0;
  logic [7:0] lfsr = 8'h50;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic run = 1'b0;
  logic snap = 1'b0;
  logic [1:0] grade = GRADE_GOOD;
  logic sensor_fault = 1'b0;
  logic signal_lost = 1'b0;
  logic batt_low = 1'b0;
  logic batt_crit = 1'b0;
  logic onoff_btn = 1'b0;
  logic [6:0] sv = 7'h00;
  logic [8:0] rv = 9'h000;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic pulse_evt, meas_upd, batt_led, power_en, awready, wready, bvalid, arready, rvalid;
  logic [6:0] spo2_in;
  logic [8:0] rate_in;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  oxd_disp_type spo2_disp, rate_disp;
  oxd_led_type pq_led;
  initial begin
    forever #10 aclk = ~aclk;
  end
  oxd_engine_model u_eng (.aclk(aclk), .aresetn(aresetn), .run(run), .spo2_val(sv),
    .rate_val(rv), .pulse_evt(pulse_evt), .meas_upd(meas_upd), .spo2_in(spo2_in),
    .rate_in(rate_in));
  oxd_display_ctrl #(.CYC_PER_MS(MS)) DUT (.aclk(aclk), .aresetn(aresetn),
    .pulse_evt(pulse_evt), .grade(grade), .sensor_fault(sensor_fault),
    .signal_lost(signal_lost), .meas_upd(meas_upd), .spo2_in(spo2_in), .rate_in(rate_in),
    .batt_low(batt_low), .batt_crit(batt_crit), .onoff_btn(onoff_btn),
    .spo2_disp(spo2_disp), .rate_disp(rate_disp), .pq_led(pq_led), .batt_led(batt_led),
    .power_en(power_en), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction : rnd
  // three digits, leading zeros blanked
  function automatic logic [11:0] dig(input int v);
    logic [3:0] h;
    logic [3:0] t;
    h = 4'(v / 100);
    t = 4'((v / 10) % 10);
    if (h == 4'h0) h = DIG_BLANK;
    if (h == DIG_BLANK && t == 4'h0) t = DIG_BLANK;
    return {h, t, 4'(v % 10)};
  endfunction : dig
  task automatic print_verdict;
    $display("compared %0d mismatched %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  task automatic timeout;
    fail_count++;
    $display("[ERR] %0t wait ran out", $time);
    print_verdict();
  endtask : timeout
  // oldest note against the result that just appeared
  task automatic take(input logic [1:0] k, input logic [47:0] a);
    oxd_note_type n;
    if (notes.size() == 0) begin
      fail_count++;
      $display("[ERR] %0t unexpected result", $time);
    end else begin
      n = notes.pop_front();
      `CHK(k, n.kind)
      `CHK(a & n.msk, n.val & n.msk)
    end
  endtask : take
  always @(posedge aclk) begin
    if (bvalid && bready) take(2'h0, {46'h0, bresp});
    if (rvalid && rready) take(2'h1, {14'h0, rresp, rdata});
    if (snap) take(2'h2, {20'h0, spo2_disp, rate_disp, pq_led, batt_led, power_en});
  end
  task automatic look(input logic [27:0] v, input logic [27:0] m);
    notes.push_back('{2'h2, {20'h0, v}, {20'h0, m}});
    snap <= 1'b1;
    @(posedge aclk);
    snap <= 1'b0;
  endtask : look
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    i = 0;
    @(posedge aclk);
    notes.push_back('{2'h0, {46'h0, r}, {48{1'b1}}});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      i++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && i < 50);
    bready <= 1'b0;
    if (i >= 50) timeout();
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    i = 0;
    @(posedge aclk);
    notes.push_back('{2'h1, {14'h0, r, d}, {48{1'b1}}});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      i++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && i < 50);
    rready <= 1'b0;
    if (i >= 50) timeout();
  endtask : rd
  task automatic wait_ms(input int n);
    repeat (n * MS) @(posedge aclk);
  endtask : wait_ms
  task automatic wait_pulse;
    int i;
    i = 0;
    while (!pulse_evt && i < 4000) begin
      @(posedge aclk);
      i++;
    end
    if (i >= 4000) timeout();
    repeat (20) @(posedge aclk);
  endtask : wait_pulse
  initial begin
    repeat (98000) @(posedge aclk);
    timeout();
  end
  // main sequence
  initial begin
    logic [11:0] es;
    logic [11:0] er;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    look({24'hBBB_BBB, 4'h0}, 28'hFFF_FFFF);
    wr(REG_CLOCK, 32'h0000_1234, RESP_OKAY);
    rd(REG_CLOCK, 32'h0000_1234, RESP_OKAY);
    rd(REG_STATUS, 32'h0000_0001, RESP_OKAY);
    rd(REG_REV, {8'h00, MAIN_REV_DEF, MEM_REV_DEF}, RESP_OKAY);
    wr(REG_REV, 32'hFFFF_FFFF, RESP_SLVERR);
    rd(4'hC, 32'h0000_0000, RESP_SLVERR);
    onoff_btn <= 1'b1;
    repeat (5) @(posedge aclk);
    onoff_btn <= 1'b0;
    wait_ms(500);
    look({24'hEEE_EEE, 4'h1}, 28'hFFF_FFF3);
    wait_ms(2000);
    look(28'h3, 28'h3);
    wait_ms(2000);
    look(28'h9, 28'hD);
    wait_ms(1000);
    look(28'h5, 28'hD);
    wait_ms(1000);
    look({DIG_BLANK, 8'h12, DIG_BLANK, 8'h34, 4'h1}, 28'hFFF_FFFF);
    wait_ms(1000);
    look({DIG_R, DIG_BLANK, DIG_BLANK, MAIN_REV_DEF, 4'h1}, 28'hFFF_FFFF);
    wait_ms(1000);
    look({DIG_N, DIG_N, DIG_BLANK, MEM_REV_DEF, 4'h1}, 28'hFFF_FFFF);
    wait_ms(1000);
    look({24'hBAB_BAB, 4'h1}, 28'hFFF_FFFF);
    sv <= 7'(60 + rnd() % 40);
    rv <= 9'(30 + rnd());
    run <= 1'b1;
    wait_ms(2500);
    for (int g = 0; g < 2; g++) begin
      grade <= 2'(g);
      wait_pulse();
      look({dig(sv), dig(rv), (g == 0) ? 2'h1 : 2'h3, 2'h1}, 28'hFFF_FFFF);
    end
    es = dig(sv);
    er = dig(rv);
    sensor_fault <= 1'b1;
    sv <= 7'(60 + rnd() % 40);
    rv <= 9'(30 + rnd());
    wait_ms(3000);
    look({DIG_DASH, es[7:0], er, 4'h1}, 28'hFFF_FFF3);
    wait_ms(7200);
    look({24'hBAB_BAB, 4'h1}, 28'hFFF_FFF3);
    sensor_fault <= 1'b0;
    repeat (10) @(posedge aclk);
    es = dig(sv);
    er = dig(rv);
    look({es, er, 4'h1}, 28'hFFF_FFF3);
    signal_lost <= 1'b1;
    wait_ms(2000);
    look({DIG_DASH, es[7:0], er, 4'h1}, 28'hFFF_FFF3);
    signal_lost <= 1'b0;
    wait_ms(100);
    grade <= GRADE_BAD;
    wait_ms(2000);
    look({es, er, 4'h1}, 28'hFFF_FFF3);
    wait_ms(8500);
    look({24'hBAB_BAB, 4'h1}, 28'hFFF_FFF3);
    grade <= GRADE_GOOD;
    batt_low <= 1'b1;
    wait_ms(50);
    look({es, er, 4'h3}, 28'hFFF_FFF3);
    batt_low <= 1'b0;
    batt_crit <= 1'b1;
    wait_pulse();
    look({24'hBBB_BBB, 4'hD}, 28'hFFF_FFFD);
    wait_ms(1200);
    batt_crit <= 1'b0;
    onoff_btn <= 1'b1;
    wait_ms(1500);
    onoff_btn <= 1'b0;
    wait_ms(50);
    look(28'h1, 28'h1);
    onoff_btn <= 1'b1;
    wait_ms(2100);
    look(28'h0, 28'h1);
    print_verdict();
  end
endmodule : oxd_display_ctrl_tb_top
`default_nettype wire
